// ==== board_pin.sv ====
`timescale 1ns/1ns
`default_nettype none
module board_pin (
  input wire logic oe_i,
  input wire logic o_i,
  input wire logic pd_i,
  input wire logic drv_i,
  input wire logic en_i,
  output logic lvl_o
);
  // device drive first, then board; a floating pin shows no stale value
  always_comb lvl_o = oe_i ? o_i : en_i ? drv_i : pd_i ? 1'h0 : !o_i;
endmodule
`default_nettype wire

// ==== pin_ctrl_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module pin_ctrl_asserts (
  input wire mclk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire power_down_standby_pin_i,
  input wire power_off_o,
  input wire standby_o,
  input wire [1:0] channel_power_mode_o,
  input wire aux_pin_a_zero_oe_o,
  input wire aux_pin_a_zero_pd_o,
  input wire aux_pin_b_zero_oe_o,
  input wire aux_pin_b_zero_pd_o,
  input wire transfer_pulse_o
);
  // a low clock enable freezes state, so checks pause with it
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);
  //////////////////////////////////////////
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready okay");
  a_pd_a_input: assert property (aux_pin_a_zero_pd_o |-> !aux_pin_a_zero_oe_o)
    else $error("pin a pulled down while driven");
  a_pd_b_input: assert property (aux_pin_b_zero_pd_o |-> !aux_pin_b_zero_oe_o)
    else $error("pin b pulled down while driven");
  a_mode_one_hot: assert property (!(power_off_o && standby_o))
    else $error("power-down and standby together");
  a_pin_overrides: assert property ((power_off_o || standby_o) |-> channel_power_mode_o == 2'h0)
    else $error("channel mode not overridden");
  a_pin_synced: assert property ($rose(power_off_o) |-> $past(power_down_standby_pin_i, 2))
    else $error("power-down without settled pin");
  a_pin_released: assert property (!power_down_standby_pin_i [*7] |-> !power_off_o && !standby_o)
    else $error("power mode held after pin release");
  a_pulse_single: assert property (transfer_pulse_o |=> !transfer_pulse_o [*3])
    else $error("transfer pulse too long or too soon");
endmodule
bind power_down_and_aux_pin_control pin_ctrl_asserts chk (.*);
`default_nettype wire

// ==== pin_ctrl_map.vh ====
`ifndef PIN_CTRL_MAP_VH
`define PIN_CTRL_MAP_VH
// byte addresses are index times four
`define IDX_PWR_PIN_DIS 8'h3f
`define IDX_PIN_PRI 8'h40
`define IDX_PIN_SEC 8'h41
`define IDX_CHIP_PWR 8'h02
`define IDX_XFER 8'h0f
`define IDX_STATUS 8'h50
`define RST_PWR_PIN_DIS 8'h00
`define RST_PIN_PRI 8'h3f
`define RST_PIN_SEC 8'h00
`define RST_CHIP_PWR 8'h00
`define PWR_DIS_BIT 7
`define PWR_FN_HI 7
`define PWR_FN_LO 6
`define PRI_B_HI 5
`define PRI_B_LO 3
`define PRI_A_HI 2
`define PRI_A_LO 0
`define SEC_B_HI 7
`define SEC_B_LO 4
`define SEC_A_HI 3
`define SEC_A_LO 0
`define FN_PWRDN 2'b00
`define FN_STBY 2'b01
`define PRI_FD 3'b000
`define PRI_LMFC 3'b001
`define PRI_SEC 3'b110
`define PRI_OFF 3'b111
`define SEC_OSC_SEL 4'b0000
`define SEC_XFER 4'b0001
`define SEC_TRIG_OUT 4'b1000
`define SEC_TRIG_IN 4'b1001
// cycles the staged-to-active copy takes
`define XFER_CYCLES 4'h4
`endif

// ==== power_down_and_aux_pin_control.v ====
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "pin_ctrl_map.vh"
module power_down_and_aux_pin_control (
  input wire mclk_i,
  input wire rst_n_i,
  input wire ce_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // power pin and resulting mode
  input wire power_down_standby_pin_i,
  output reg power_off_o,
  output reg standby_o,
  output reg [1:0] channel_power_mode_o,
  // internal sources for aux pins
  input wire fast_detect_a_i,
  input wire fast_detect_b_i,
  input wire lmfc_i,
  input wire master_next_trigger_i,
  // aux pins, three-signal form
  input wire aux_pin_a_zero_i,
  output reg aux_pin_a_zero_o,
  output reg aux_pin_a_zero_oe_o,
  output reg aux_pin_a_zero_pd_o,
  input wire aux_pin_b_zero_i,
  output reg aux_pin_b_zero_o,
  output reg aux_pin_b_zero_oe_o,
  output reg aux_pin_b_zero_pd_o,
  // decoded input roles
  output reg [1:0] numeric_oscillator_sel_o,
  output reg slave_next_trigger_in_o,
  output reg transfer_pulse_o
);

////////////////////////////////////////////////////////////////////////////////
// overview of the block
// - three software registers shape the power pin and two aux pins
// - disable register: bit 7 only, other bits read zero
// - primary register: power pin function in 7:6, pin b role 5:3, pin a 2:0
// - secondary register: pin b role 7:4, pin a role 3:0
// - secondary role only counts while the primary role is 110
// - chip power register: channel mode in 1:0, overridden by the pin
// - transfer register: bit 0 starts a copy, reads one until done
// - status register: synchronised levels and the resulting modes
//
// bus behaviour
// - zero wait states, so the master never stalls on this slave
// - read data is latched in the address phase and stands until
//   the next read address phase
// - writes land at the end of the data phase
// - hsize is ignored, every access is treated as a whole word
// - unmapped reads give zero, unmapped writes are dropped
//
// power pin behaviour
// - pin level goes through three flops before use
// - a level is accepted only once stages two and three agree,
//   which filters single-cycle glitches at the cost of latency
// - function 00 gives power-down, 01 standby, 10 and 11 nothing
// - while the pin acts, the channel mode output is forced to 00
//
// aux pin behaviour
// - each pin has a value, an output enable and a pull-down enable
// - output enable high means this block drives the pin
// - pull-down only for primary 111; other unused codes float
// - input roles read the synchronised level of the pin
// - transfer role reacts to a rising edge, not to a level
//
// clock enable
// - low clock enable freezes every register, bus capture included
// - the bus still shows ready, so masters must not issue requests
//   while the enable is low; such requests are simply lost
//
// limitations
// - a transfer request while one is pending is ignored
// - the copy itself happens outside this block, on the pulse
////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] pwr_pin_dis;
reg [7:0] pin_pri;
reg [7:0] pin_sec;
reg [7:0] chip_pwr;
reg xfer_req;
reg [3:0] xfer_cnt;
reg [2:0] pdn_sync;
reg [2:0] a_sync;
reg [2:0] b_sync;
reg pdn_lvl;
reg a_lvl;
reg b_lvl;
reg a_lvl_d;
reg b_lvl_d;
reg dp_act;
reg dp_wr;
reg [7:0] dp_idx;

// primary code 110 with the given secondary code
function role_is;
  input [2:0] pri;
  input [3:0] sec;
  input [3:0] want;
  begin
    role_is = (pri == `PRI_SEC) && (sec == want);
  end
endfunction

wire [2:0] pri_a = pin_pri[`PRI_A_HI:`PRI_A_LO];
wire [2:0] pri_b = pin_pri[`PRI_B_HI:`PRI_B_LO];
wire [3:0] sec_a = pin_sec[`SEC_A_HI:`SEC_A_LO];
wire [3:0] sec_b = pin_sec[`SEC_B_HI:`SEC_B_LO];
wire [1:0] pwr_fn = pin_pri[`PWR_FN_HI:`PWR_FN_LO];

////////////////////////////////////////////////////////////////////////////////
// bus: zero wait state, always okay
assign hreadyout_o = 1'b1;
assign hresp_o = 1'b0;
wire take = hsel_i && hready_i && htrans_i[1];

// address phase capture; index is byte address over four
always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    dp_act <= 1'b0;
    dp_wr <= 1'b0;
    dp_idx <= 8'h00;
  end else if (ce_i) begin
    dp_act <= take;
    dp_wr <= take && hwrite_i;
    dp_idx <= haddr_i[9:2];
  end
end

// read data; unmapped reads zero
always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    hrdata_o <= 32'h0000_0000;
  end else if (ce_i && take && !hwrite_i) begin
    case (haddr_i[9:2])
      `IDX_PWR_PIN_DIS: hrdata_o <= {24'h00_0000, pwr_pin_dis};
      `IDX_PIN_PRI: hrdata_o <= {24'h00_0000, pin_pri};
      `IDX_PIN_SEC: hrdata_o <= {24'h00_0000, pin_sec};
      `IDX_CHIP_PWR: hrdata_o <= {24'h00_0000, chip_pwr};
      `IDX_XFER: hrdata_o <= {31'h0000_0000, xfer_req};
      `IDX_STATUS: hrdata_o <= {27'h000_0000, pdn_lvl, a_lvl, b_lvl, power_off_o, standby_o};
      default: hrdata_o <= 32'h0000_0000;
    endcase
  end
end

// register writes; reserved bits of the disable register stay zero
always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    pwr_pin_dis <= `RST_PWR_PIN_DIS;
    pin_pri <= `RST_PIN_PRI;
    pin_sec <= `RST_PIN_SEC;
    chip_pwr <= `RST_CHIP_PWR;
  end else if (ce_i && dp_wr) begin
    case (dp_idx)
      `IDX_PWR_PIN_DIS: pwr_pin_dis <= {hwdata_i[7], 7'h00};
      `IDX_PIN_PRI: pin_pri <= hwdata_i[7:0];
      `IDX_PIN_SEC: pin_sec <= hwdata_i[7:0];
      `IDX_CHIP_PWR: chip_pwr <= {6'h00, hwdata_i[1:0]};
      default: ;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// three-stage sync; a level changes once stages two and three agree
always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    pdn_sync <= 3'h0;
    a_sync <= 3'h0;
    b_sync <= 3'h0;
    pdn_lvl <= 1'b0;
    a_lvl <= 1'b0;
    b_lvl <= 1'b0;
    a_lvl_d <= 1'b0;
    b_lvl_d <= 1'b0;
  end else if (ce_i) begin
    pdn_sync <= {pdn_sync[1:0], power_down_standby_pin_i};
    a_sync <= {a_sync[1:0], aux_pin_a_zero_i};
    b_sync <= {b_sync[1:0], aux_pin_b_zero_i};
    if (pdn_sync[1] == pdn_sync[2]) pdn_lvl <= pdn_sync[2];
    if (a_sync[1] == a_sync[2]) a_lvl <= a_sync[2];
    if (b_sync[1] == b_sync[2]) b_lvl <= b_sync[2];
    a_lvl_d <= a_lvl;
    b_lvl_d <= b_lvl;
  end
end

////////////////////////////////////////////////////////////////////////////////
// power pin decode
wire pin_on = !pwr_pin_dis[`PWR_DIS_BIT] && pdn_lvl;
always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    power_off_o <= 1'b0;
    standby_o <= 1'b0;
    channel_power_mode_o <= 2'b00;
  end else if (ce_i) begin
    // codes 10 and 11 fall through with no effect
    power_off_o <= pin_on && (pwr_fn == `FN_PWRDN);
    standby_o <= pin_on && (pwr_fn == `FN_STBY);
    // pin wins over the channel mode setting
    if (pin_on && (pwr_fn == `FN_PWRDN || pwr_fn == `FN_STBY)) begin
      channel_power_mode_o <= 2'b00;
    end else begin
      channel_power_mode_o <= chip_pwr[1:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// chip transfer: register bit or rising edge on a transfer-role pin
wire a_xfer_edge = role_is(pri_a, sec_a, `SEC_XFER) && a_lvl && !a_lvl_d;
wire b_xfer_edge = role_is(pri_b, sec_b, `SEC_XFER) && b_lvl && !b_lvl_d;
wire sw_xfer = dp_wr && (dp_idx == `IDX_XFER) && hwdata_i[0];
always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    xfer_req <= 1'b0;
    xfer_cnt <= 4'h0;
    transfer_pulse_o <= 1'b0;
  end else if (ce_i) begin
    transfer_pulse_o <= 1'b0;
    if (!xfer_req && (sw_xfer || a_xfer_edge || b_xfer_edge)) begin
      xfer_req <= 1'b1;
      xfer_cnt <= `XFER_CYCLES;
    end else if (xfer_req) begin
      // copy strobe at the end; flag clears itself on the same edge
      if (xfer_cnt == 4'h1) begin
        transfer_pulse_o <= 1'b1;
        xfer_req <= 1'b0;
      end
      xfer_cnt <= xfer_cnt - 4'h1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// input-role decode; reserved codes give no effect
always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    numeric_oscillator_sel_o <= 2'b00;
    slave_next_trigger_in_o <= 1'b0;
  end else if (ce_i) begin
    numeric_oscillator_sel_o <= {role_is(pri_b, sec_b, `SEC_OSC_SEL) && b_lvl,
                                 role_is(pri_a, sec_a, `SEC_OSC_SEL) && a_lvl};
    slave_next_trigger_in_o <= (role_is(pri_a, sec_a, `SEC_TRIG_IN) && a_lvl) ||
                               (role_is(pri_b, sec_b, `SEC_TRIG_IN) && b_lvl);
  end
end

////////////////////////////////////////////////////////////////////////////////
// pin drive notes
// - all three pin controls are registered, so a role change shows
//   on the pin one edge after the register write lands
// - sources are same-clock signals and are not synchronised
// - registering the value costs one cycle of delay on the
//   fast-detect flags, traded for glitch-free pin edges
// - an input role leaves the enable low, so the board may drive
// - the pull-down and the enable are never high together
// - reserved primary codes 010 to 101 leave the pin floating with
//   no pull-down, so the board should bias it
// - reserved secondary codes behave the same way
// - the trigger-out role drives the internal trigger source only
//   while secondary code 1000 is held
// - switching a pin from output to input may leave the board
//   level briefly unknown; input roles wait for the synchroniser
//
// after reset every pin is an input with pull-down, matching
// primary code 111 in both fields
////////////////////////////////////////////////////////////////////////////////
// output drive per pin; undriven with pull-down when off
always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    aux_pin_a_zero_o <= 1'b0;
    aux_pin_a_zero_oe_o <= 1'b0;
    aux_pin_a_zero_pd_o <= 1'b1;
    aux_pin_b_zero_o <= 1'b0;
    aux_pin_b_zero_oe_o <= 1'b0;
    aux_pin_b_zero_pd_o <= 1'b1;
  end else if (ce_i) begin
    aux_pin_a_zero_pd_o <= (pri_a == `PRI_OFF);
    aux_pin_b_zero_pd_o <= (pri_b == `PRI_OFF);
    case (pri_a)
      `PRI_FD: begin
        aux_pin_a_zero_o <= fast_detect_a_i;
        aux_pin_a_zero_oe_o <= 1'b1;
      end
      `PRI_LMFC: begin
        aux_pin_a_zero_o <= lmfc_i;
        aux_pin_a_zero_oe_o <= 1'b1;
      end
      `PRI_SEC: begin
        aux_pin_a_zero_o <= master_next_trigger_i;
        aux_pin_a_zero_oe_o <= (sec_a == `SEC_TRIG_OUT);
      end
      default: begin
        aux_pin_a_zero_o <= 1'b0;
        aux_pin_a_zero_oe_o <= 1'b0;
      end
    endcase
    case (pri_b)
      `PRI_FD: begin
        aux_pin_b_zero_o <= fast_detect_b_i;
        aux_pin_b_zero_oe_o <= 1'b1;
      end
      `PRI_LMFC: begin
        aux_pin_b_zero_o <= lmfc_i;
        aux_pin_b_zero_oe_o <= 1'b1;
      end
      `PRI_SEC: begin
        aux_pin_b_zero_o <= master_next_trigger_i;
        aux_pin_b_zero_oe_o <= (sec_b == `SEC_TRIG_OUT);
      end
      default: begin
        aux_pin_b_zero_o <= 1'b0;
        aux_pin_b_zero_oe_o <= 1'b0;
      end
    endcase
  end
end

endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pin_ctrl_map.vh"
module tb;
  logic mclk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic ce_i = 1'h1;
  logic hsel_i = 1'h0;
  logic hwrite_i = 1'h0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = '0;
  logic [31:0] hwdata_i = '0;
  logic power_down_standby_pin_i = 1'h0;
  logic fast_detect_a_i = 1'h1;
  logic fast_detect_b_i = 1'h0;
  logic lmfc_i = 1'h1;
  logic master_next_trigger_i = 1'h0;
  logic drv_a = 1'h0, en_a = 1'h0, drv_b = 1'h0, en_b = 1'h0;
  wire hready_i, hreadyout_o, hresp_o, power_off_o, standby_o, transfer_pulse_o;
  wire aux_pin_a_zero_i, aux_pin_a_zero_o, aux_pin_a_zero_oe_o, aux_pin_a_zero_pd_o;
  wire aux_pin_b_zero_i, aux_pin_b_zero_o, aux_pin_b_zero_oe_o, aux_pin_b_zero_pd_o;
  wire slave_next_trigger_in_o;
  wire [1:0] channel_power_mode_o, numeric_oscillator_sel_o;
  wire [31:0] hrdata_o;
  int n_mismatch = 0, tests_run = 0;
  logic [31:0] q;
  logic [11:0] cs = 12'h05c8;
  // single slave, so its ready is the bus ready
  assign hready_i = hreadyout_o;
  power_down_and_aux_pin_control DUT (.*);
  board_pin pa (.oe_i(aux_pin_a_zero_oe_o), .o_i(aux_pin_a_zero_o), .pd_i(aux_pin_a_zero_pd_o),
    .drv_i(drv_a), .en_i(en_a), .lvl_o(aux_pin_a_zero_i));
  board_pin pb (.oe_i(aux_pin_b_zero_oe_o), .o_i(aux_pin_b_zero_o), .pd_i(aux_pin_b_zero_pd_o),
    .drv_i(drv_b), .en_i(en_b), .lvl_o(aux_pin_b_zero_i));
  //////////////////////////////////////////
  initial forever #2 mclk_i = ~mclk_i;
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  // registers are word indexes, byte address is four times that
  task xf(input logic w, input logic [7:0] i, input logic [7:0] d);
    hsel_i <= 1'h1;
    htrans_i <= 2'h2;
    haddr_i <= {22'h0, i, 2'h0};
    hwrite_i <= w;
    do @(posedge mclk_i); while (hreadyout_o !== 1'h1);
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge mclk_i); while (hreadyout_o !== 1'h1);
    q = hrdata_o;
  endtask
  task rdc(input logic [7:0] i, input logic [7:0] e);
    xf(1'h0, i, 8'h0);
    chk(q, {24'h0, e});
  endtask
  task wp;
    int i;
    i = 0;
    while (transfer_pulse_o !== 1'h1 && i < 20) begin
      @(posedge mclk_i);
      i++;
    end
    chk(i < 20, 1);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    cyc(5000);
    n_mismatch++;
    conclude;
  end
  //////////////////////////////////////////
  initial begin
    cyc(12);
    rst_n_i <= 1'h1;
    rdc(`IDX_PWR_PIN_DIS, `RST_PWR_PIN_DIS);
    rdc(`IDX_PIN_PRI, `RST_PIN_PRI);
    rdc(`IDX_PIN_SEC, `RST_PIN_SEC);
    rdc(8'h70, 8'h0);
    chk({aux_pin_a_zero_oe_o, aux_pin_a_zero_pd_o, aux_pin_b_zero_pd_o}, 3);
    $display("end reset test");
    xf(1'h1, `IDX_CHIP_PWR, 8'h3);
    power_down_standby_pin_i <= 1'h1;
    for (int f = 0; f < 4; f++) begin
      xf(1'h1, `IDX_PIN_PRI, {f[1:0], 6'h3f});
      cyc(8);
      chk({power_off_o, standby_o}, {f == 0, f == 1});
      chk(channel_power_mode_o, f < 2 ? 0 : 3);
    end
    xf(1'h1, `IDX_PWR_PIN_DIS, 8'h80);
    xf(1'h1, `IDX_PIN_PRI, 8'h3f);
    cyc(8);
    chk(power_off_o, 0);
    xf(1'h1, `IDX_PWR_PIN_DIS, 8'h0);
    cyc(8);
    chk(power_off_o, 1);
    // low enable must freeze the mode even though the pin drops
    ce_i <= 1'h0;
    power_down_standby_pin_i <= 1'h0;
    cyc(8);
    chk(power_off_o, 1);
    ce_i <= 1'h1;
    cyc(8);
    chk(power_off_o, 0);
    $display("end power pin test");
    // primary codes 000, 001, 111, 010 on both pins
    for (int k = 0; k < 4; k++) begin
      xf(1'h1, `IDX_PIN_PRI, {2'h2, cs[3*k +: 3], cs[3*k +: 3]});
      cyc(2);
      chk({aux_pin_a_zero_oe_o, aux_pin_b_zero_oe_o}, k < 2 ? 3 : 0);
      chk({aux_pin_a_zero_pd_o, aux_pin_b_zero_pd_o}, k == 2 ? 3 : 0);
      chk({aux_pin_a_zero_o, aux_pin_b_zero_o} & {2{k < 2}}, k == 1 ? 3 : k == 0 ? 2 : 0);
    end
    $display("end primary test");
    xf(1'h1, `IDX_PIN_SEC, 8'h98);
    master_next_trigger_i <= 1'h1;
    en_b <= 1'h1;
    drv_b <= 1'h1;
    xf(1'h1, `IDX_PIN_PRI, 8'hb6);
    cyc(8);
    chk({aux_pin_a_zero_oe_o, aux_pin_a_zero_o}, 3);
    chk(slave_next_trigger_in_o, 1);
    xf(1'h1, `IDX_PIN_PRI, 8'h86);
    cyc(8);
    chk(slave_next_trigger_in_o, 0);
    xf(1'h1, `IDX_PIN_SEC, 8'h10);
    drv_b <= 1'h0;
    en_a <= 1'h1;
    drv_a <= 1'h1;
    xf(1'h1, `IDX_PIN_PRI, 8'hb6);
    cyc(8);
    chk(numeric_oscillator_sel_o, 1);
    drv_b <= 1'h1;
    wp();
    $display("end secondary test");
    xf(1'h1, `IDX_XFER, 8'h1);
    rdc(`IDX_XFER, 8'h1);
    wp();
    rdc(`IDX_XFER, 8'h0);
    $display("end transfer test");
    conclude;
  end
endmodule
`default_nettype wire
